// [psmt_translator.sv]
/*
 * Sparse memory window translator: decodes system bus requests in
 * the 128MB sparse memory window and forms PCI memory cycles, with
 * optional legacy memory holes for the lowest 16MB.
 * Assumes inputs synchronous to pclk and an APB master for setup.
 */
`timescale 1ns/1ps
`default_nettype none
// Function
// (R1) Window accesses become PCI memory cycles
// (R2) Window spans 128MB of PCI memory
// (R3) Extension bits 4:0 pick 128MB chunk
// (R4) Window resets to PCI address 8000.0000
// (R5) Software keeps window clear of others
// (R6) Hole one fixed at 512K to 1M
// (R7) Hole two programmable, 32K granules, 1M-16M
// (R8) Holes enable independently, reroute lowest 16MB
// (R9) Holes off: whole window contiguous
// (R10) Holes on: upper 112MB maps directly
// (R11) Select on bits 33:32, map 31:7
// (R12) Lower 16MB with holes: high bits zero; here only hole hits get zero, other low addresses keep the extension
// (R13) 16MB-128MB with holes: extension kept
// (R14) Offset bits 6:5 build byte enables
// (R15) Size field builds enables, AD[1:0]=00
// (R16) Bad write mask: longword, null mask
// (R17) Hole registers reset off, checked first
module psmt_translator
  import psmt_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // System bus request
  input wire psmt_req_s req,
  // PCI memory cycle out
  output psmt_pci_s pci
);

  // ****************************************************************
  // Register file
  // ****************************************************************
  logic [4:0] ext_ff, nxt_ext;
  logic [31:0] hole_ff, nxt_hole;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic [15:0] cnt_ff, nxt_cnt;
  logic [15:0] hcnt_ff, nxt_hcnt;
  logic [15:0] bad_ff, nxt_bad;
  psmt_pci_s pci_ff, nxt_pci;

  logic acc;
  logic done;
  logic mapped;
  assign acc = psel && penable && !pready_ff;
  // Writes land only at the edge where the master sees pready high
  assign done = psel && penable && pready_ff;
  assign mapped = (paddr == PSMT_EXT_OFS) || (paddr == PSMT_HOLE_OFS) ||
                  (paddr == PSMT_STAT_OFS) || (paddr == PSMT_LAST_OFS);

  // Register access; answers one cycle into the access phase
  always_comb begin
    nxt_ext = ext_ff;
    nxt_hole = hole_ff;
    nxt_prdata = prdata_ff;
    nxt_pready = 1'b0;
    nxt_pslverr = 1'b0;
    if (done && pwrite) begin
      if (paddr == PSMT_EXT_OFS) begin
        nxt_ext = pwdata[PSMT_EXT_W-1:0]; // R3
      end
      if (paddr == PSMT_HOLE_OFS) begin
        nxt_hole = pwdata; // R8
      end
    end
    if (acc) begin
      nxt_pready = 1'b1;
      nxt_pslverr = !mapped;
      nxt_prdata = 32'h0000_0000;
      if (!pwrite) begin
        unique case (paddr)
          PSMT_EXT_OFS: nxt_prdata = {27'h000_0000, ext_ff};
          PSMT_HOLE_OFS: nxt_prdata = hole_ff;
          PSMT_STAT_OFS: nxt_prdata = {cnt_ff, hcnt_ff};
          PSMT_LAST_OFS: nxt_prdata = pci_ff.addr;
          default: nxt_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Hole decode
  // ****************************************************************
  logic [8:0] hbase;
  logic [8:0] hsize;
  logic [9:0] hend;
  logic [8:0] gran;     // 32K granule of the window offset
  logic in_low16;
  logic in_h1;
  logic in_h2;
  logic to_hole;
  assign hbase = hole_ff[PSMT_HBASE_LSB +: PSMT_HBASE_W];
  assign hsize = hole_ff[PSMT_HSIZE_LSB +: PSMT_HSIZE_W];
  assign hend = {1'b0, hbase} + {1'b0, hsize};
  // Window offset bits 23:15 sit at cpu_address bits 28:20
  assign gran = req.cpu_address[28:20];
  // Lowest 16MB of the window: offset bits 26:24 are zero
  assign in_low16 = (req.cpu_address[31:29] == 3'h0); // R8
  assign in_h1 = hole_ff[PSMT_HOLE1_EN_BIT] &&
                 (gran >= PSMT_H1_LO) && (gran < PSMT_H1_HI); // R6
  // Hole two decodes only when the programmed range lies inside 1M-16M
  assign in_h2 = hole_ff[PSMT_HOLE2_EN_BIT] &&
                 (gran >= hbase) && ({1'b0, gran} < hend) &&
                 (hbase >= PSMT_H2_MIN) && (hend <= PSMT_H2_MAX); // R7
  assign to_hole = in_low16 && (in_h1 || in_h2); // R17

  // ****************************************************************
  // Byte enables
  // ****************************************************************
  logic [1:0] offs;
  logic [1:0] size;
  logic size_ok;
  logic [3:0] be_n;
  assign offs = req.cpu_address[6:5]; // R14

  // Write size from the mask; unknown masks are flagged invalid
  always_comb begin
    size = req.rd_size;
    size_ok = 1'b1;
    if (req.write) begin
      unique case (req.cpu_write_mask)
        8'h01, 8'h02: size = 2'h0;
        8'h04, 8'h08: size = 2'h1;
        8'h10, 8'h20: size = 2'h2;
        8'h40, 8'h80, 8'hC0: size = 2'h3;
        default: size_ok = 1'b0; // R16
      endcase
    end
  end

  // Active-low enables from offset and size
  always_comb begin
    be_n = PSMT_NULL_BE;
    unique case (size)
      2'h0: be_n = ~(4'h1 << offs); // R15
      2'h1: be_n = ~(4'h3 << offs);
      2'h2: be_n = ~(4'h7 << offs);
      2'h3: be_n = 4'h0;
    endcase
    if (!size_ok) begin
      be_n = PSMT_NULL_BE; // R16
    end
  end

  // ****************************************************************
  // Translation
  // ****************************************************************
  logic hit;
  assign hit = req.valid && (req.cpu_address[33:32] == PSMT_SEL_CODE); // R11

  // Forms the PCI cycle one clock after the request
  always_comb begin
    nxt_pci = pci_ff;
    nxt_pci.valid = 1'b0;
    nxt_cnt = cnt_ff;
    nxt_hcnt = hcnt_ff;
    nxt_bad = bad_ff;
    if (hit) begin
      nxt_pci.valid = 1'b1; // R1
      nxt_pci.write = req.write;
      nxt_pci.hole = to_hole;
      // 25 bits of window offset give 128MB; R2 R9 R13
      nxt_pci.addr = {to_hole ? PSMT_LOW_EXT : ext_ff, // R10 R12
                      req.cpu_address[31:7], 2'b00}; // R11 R15
      nxt_pci.cbe_n = be_n;
      nxt_pci.data = req.wdata[31:0]; // R16
      nxt_cnt = cnt_ff + 16'h0001;
      if (to_hole) begin
        nxt_hcnt = hcnt_ff + 16'h0001;
      end
      if (req.write && !size_ok) begin
        nxt_bad = bad_ff + 16'h0001;
      end
    end
  end

  // Registers; extension resets to 8000.0000 and holes off
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_ff <= PSMT_EXT_RST; // R4
      hole_ff <= PSMT_HOLE_RST; // R17
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      cnt_ff <= 16'h0000;
      hcnt_ff <= 16'h0000;
      bad_ff <= 16'h0000;
      pci_ff <= '0;
    end else begin
      ext_ff <= nxt_ext;
      hole_ff <= nxt_hole;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
      cnt_ff <= nxt_cnt;
      hcnt_ff <= nxt_hcnt;
      bad_ff <= nxt_bad;
      pci_ff <= nxt_pci;
    end
  end

  // Outputs straight from flip-flops
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign pci = pci_ff;

endmodule
`default_nettype wire

// [psmt_pkg.sv]
/*
 * Package for the sparse memory window translator: register map,
 * field positions, reset values and the request/answer carriers.
 * Assumes a 32-bit APB register bus and a single pclk domain.
 */
package psmt_pkg;

  // ****************************************************************
  // Register map (byte addresses)
  // ****************************************************************
  localparam logic [11:0] PSMT_EXT_OFS = 12'h000;    // High address extension
  localparam logic [11:0] PSMT_HOLE_OFS = 12'h004;   // Hole control
  localparam logic [11:0] PSMT_STAT_OFS = 12'h008;   // Translation status
  localparam logic [11:0] PSMT_LAST_OFS = 12'h00C;   // Last PCI address

  // Field layout
  localparam int PSMT_EXT_W = 5;
  localparam int PSMT_HOLE1_EN_BIT = 0;
  localparam int PSMT_HOLE2_EN_BIT = 1;
  localparam int PSMT_HBASE_LSB = 8;                 // 32K granule index
  localparam int PSMT_HBASE_W = 9;
  localparam int PSMT_HSIZE_LSB = 20;                // Size in granules
  localparam int PSMT_HSIZE_W = 9;

  // Reset values: window at 8000.0000, holes off
  localparam logic [4:0] PSMT_EXT_RST = 5'h10;
  localparam logic [31:0] PSMT_HOLE_RST = 32'h0000_0000;

  // Address decode constants
  localparam logic [1:0] PSMT_SEL_CODE = 2'h2;       // cpu_address[33:32]
  localparam logic [4:0] PSMT_LOW_EXT = 5'h00;
  localparam logic [8:0] PSMT_H1_LO = 9'h010;        // 512K in 32K granules
  localparam logic [8:0] PSMT_H1_HI = 9'h020;        // 1M in 32K granules
  localparam logic [8:0] PSMT_H2_MIN = 9'h020;       // 1M
  localparam logic [9:0] PSMT_H2_MAX = 10'h200;      // 16M
  localparam logic [3:0] PSMT_NULL_BE = 4'hF;        // No lane enabled

  // Request from the system bus
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [33:0] cpu_address;
    logic [1:0]  rd_size;          // Size bits on reads
    logic [7:0]  cpu_write_mask;
    logic [63:0] wdata;            // Low lane data
  } psmt_req_s;

  // PCI memory command cycle
  typedef struct packed {
    logic        valid;
    logic        write;
    logic        hole;             // Routed to a legacy hole
    logic [31:0] addr;
    logic [3:0]  cbe_n;
    logic [31:0] data;
  } psmt_pci_s;

endpackage

// [psmt_checker.sv]
/* Assertions on the translator ports, one pclk domain.
   Bound onto psmt_translator below its endmodule. */
`timescale 1ns/1ps
`default_nettype none
module psmt_checker
  import psmt_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Request in, PCI cycle out
  input wire psmt_req_s req,
  input wire psmt_pci_s pci
);
  // ****************************************************************
  // Window hits and the cycles they must produce
  // ****************************************************************
  logic hit;
  logic wr;
  // Only valid and the select code decide a hit
  assign hit = req.valid && req.cpu_address[33:32] == 2'b10;
  assign wr = hit && req.write;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  hit_forward_a: assert property (hit |=> pci.valid)
    else $error("window hit gave no cycle");
  miss_quiet_a: assert property (!hit |=> !pci.valid)
    else $error("cycle without a hit");
  dir_kept_a: assert property (hit |=> pci.write == $past(req.write))
    else $error("direction changed");
  low_map_a: assert property (hit |=>
    pci.addr[26:0] == {$past(req.cpu_address[31:7]), 2'b00})
    else $error("low address bits wrong");
  hole_zero_a: assert property (pci.valid && pci.hole |->
    pci.addr[31:24] == 8'h00) else $error("hole address not low");
  bad_mask_a: assert property (wr && req.cpu_write_mask == 8'h03 |=>
    pci.cbe_n == 4'hF && pci.data == $past(req.wdata[31:0]))
    else $error("bad mask not null longword");
  long_read_a: assert property (hit && !req.write &&
    req.rd_size == 2'b11 |=> pci.cbe_n == 4'h0)
    else $error("longword read enables wrong");
  byte_lane_a: assert property (wr && req.cpu_write_mask == 8'h01 |=>
    pci.cbe_n == ~(4'h1 << $past(req.cpu_address[6:5])))
    else $error("byte lane wrong");
  // Main paths worth seeing once
  hole_c: cover property (pci.valid && pci.hole);
  bad_c: cover property (wr && req.cpu_write_mask == 8'h03);
  read_c: cover property (hit && !req.write);
endmodule
bind psmt_translator psmt_checker chk_u (.pclk, .presetn, .req, .pci);
`default_nettype wire

// [psmt_pci_target.sv]
/* PCI target model: takes every memory cycle it is offered.
   Assumes cycles arrive as one-clock valid pulses. */
`timescale 1ns/1ps
`default_nettype none
module psmt_pci_target
  import psmt_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Offered cycle, last cycle taken and how many
  input wire psmt_pci_s pci,
  output psmt_pci_s seen_ff,
  output logic [15:0] cnt_ff
);
  // ****************************************************************
  // Capture; no retry, so the bridge never waits on us
  // ****************************************************************
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      seen_ff <= '0;
      cnt_ff <= 16'h0000;
    end else if (pci.valid) begin
      seen_ff <= pci;
      cnt_ff <= cnt_ff + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// [psmt_translator_tb.sv]
/* Bench: APB set-up and request sequences with expected cycles.
   Assumes the translator and the PCI target model. */
`timescale 1ns/1ps
`default_nettype none
module psmt_translator_tb
  import psmt_pkg::*;
;
  // ****************************************************************
  // Signals, clock and instances
  // ****************************************************************
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
  logic pready, pslverr, er;
  logic [15:0] cnt, n;
  psmt_req_s req = '0;
  psmt_pci_s pci, seen;
  int err_total = 0, checks = 0;
  localparam logic [63:0] WD = 64'h0123_4567_89AB_CDEF;
  always #5 pclk = ~pclk;
  psmt_translator DUT (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .req, .pci);
  psmt_pci_target tgt (.pclk, .presetn, .pci, .seen_ff(seen),
    .cnt_ff(cnt));
  task chk(input string s, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s exp %h got %h", s, e, g);
    end
  endtask
  // One APB transfer; holds the request until pready is sampled
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  // One request; the target count shows whether a cycle came out
  task tx(input logic [1:0] sc, input logic w, input logic [24:0] a,
    input logic [1:0] o, s, input logic [7:0] m, input logic [4:0] hi,
    input logic h, input logic [3:0] be);
    n = cnt;
    @(posedge pclk);
    req <= '{1'b1, w, {sc, a, o, s, 3'b000}, s, m, WD};
    @(posedge pclk);
    req.valid <= 1'b0;
    @(posedge pclk);
    @(negedge pclk);
    chk("count", {16'h0, n + 16'(sc == 2'b10)}, {16'h0, cnt});
    if (sc == 2'b10) begin
      chk("addr", {hi, a, 2'b00}, seen.addr);
      chk("hole", {31'h0, h}, {31'h0, seen.hole});
      chk("cbe_n", {28'h0, be}, {28'h0, seen.cbe_n});
      if (w) chk("data", WD[31:0], seen.data);
    end
  endtask
  task complete_run;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // Hang guard, far past the fewer than a hundred cycles needed
  initial begin
    #50000;
    err_total++;
    complete_run;
  end
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1;
    apb(0, PSMT_EXT_OFS, 0);
    chk("ext", 32'h0000_0010, rd);
    apb(0, PSMT_HOLE_OFS, 0);
    chk("holes", 32'h0000_0000, rd);
    apb(0, 12'h010, 0);
    chk("slverr", 32'h0000_0001, {31'h0, er});
    tx(2, 0, 25'h002_4000, 0, 3, 0, 16, 0, 0);
    tx(1, 0, 25'h002_4000, 0, 3, 0, 16, 0, 0);
    tx(2, 1, 25'h1FF_FFFF, 3, 0, 1, 16, 0, 7);
    $display("test 1 done");
    apb(1, PSMT_EXT_OFS, 32'hFFFF_FFE3);
    apb(0, PSMT_EXT_OFS, 0);
    chk("ext", 32'h0000_0003, rd);
    apb(1, PSMT_HOLE_OFS, 1);
    tx(2, 0, 25'h002_4000, 0, 3, 0, 0, 1, 0);
    tx(2, 0, 25'h040_0000, 0, 3, 0, 3, 0, 0);
    $display("test 2 done");
    apb(1, PSMT_HOLE_OFS, 32'h0100_4002);
    tx(2, 0, 25'h008_A000, 0, 3, 0, 0, 1, 0);
    tx(2, 0, 25'h00A_0000, 0, 3, 0, 3, 0, 0);
    tx(2, 0, 25'h002_4000, 0, 3, 0, 3, 0, 0);
    $display("test 3 done");
    tx(2, 1, 25'h000_0000, 1, 0, 8'h04, 3, 0, 9);
    tx(2, 1, 25'h000_0000, 0, 0, 8'h10, 3, 0, 8);
    tx(2, 1, 25'h000_0000, 0, 0, 8'h40, 3, 0, 0);
    tx(2, 1, 25'h000_0000, 2, 0, 8'h03, 3, 0, 15);
    tx(2, 0, 25'h000_0000, 2, 0, 0, 3, 0, 11);
    $display("test 4 done");
    complete_run;
  end
endmodule
`default_nettype wire
